// >>> hdl/pfg_bus_if.sv
// interface: cpu data bus and fault pins between host and device
`timescale 1ns/1ps
interface pfg_bus_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic irq;
  logic event_pin;
  modport dev (
    input addr, wdata, wr, rd, event_pin,
    output rdata, irq
  );
  modport host (
    output addr, wdata, wr, rd, event_pin,
    input rdata, irq
  );
endinterface

// >>> hdl/pfg_device.sv
// device end: fault guard, control registers and wide access latch
`timescale 1ns/1ps
module pfg_device (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  pfg_bus_if.dev bus,
  input wire logic comparator_result_i,
  input wire logic [1:0] wave_i,
  input wire logic [1:0] port_b_output_i,
  output logic [1:0] pwm_pin_o,
  output logic [1:0] force_compare_o,
  output logic [1:0] pwm_enable_o,
  output logic [pfg_pkg::PFG_VAL_W-1:0] count_value_o
);
  import pfg_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0] ctl_a;
    logic [7:0] ctl_d;
    logic [1:0] high;
    logic [PFG_NUM_VAL-1:0][PFG_VAL_W-1:0] vals;
    logic flag;
    logic irq;
    logic [1:0] foc;
    logic [1:0] pins;
    logic [7:0] rdata;
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [PFG_FILT_LEN-2:0] hist;
    logic filt;
    logic prev;
  } pfg_dev_s;

  pfg_dev_s st_ff;
  pfg_dev_s nxt_st;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [2:0] val_index(input logic [7:0] a);
    val_index = 3'(a - PFG_CNT_ADDR);
  endfunction

  function automatic logic is_val(input logic [7:0] a);
    is_val = (a >= PFG_CNT_ADDR) && (a <= PFG_CMPD_ADDR);
  endfunction

  function automatic logic pin_mux(input logic [1:0] mode,
                                   input logic wave, input logic port);
    pin_mux = (|mode) ? wave : port;
  endfunction

  function automatic logic edge_seen(input logic rising,
                                     input logic now, input logic was);
    edge_seen = rising ? (now & ~was) : (~now & was);
  endfunction

  // ************************************************************
  // combinational nets
  // ************************************************************
  logic [PFG_FILT_LEN-1:0] win;
  logic pin_s;
  logic src;
  logic fin;
  logic edge_hit;
  logic trip;
  logic [2:0] vi;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.foc = 2'h0;
    nxt_st.rdata = 8'h00;
    nxt_st.irq = 1'b0;
    vi = val_index(bus.addr);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    // two stages, only stage two is read
    nxt_st.sync_a = {st_ff.sync_a[0], bus.event_pin};
    nxt_st.sync_b = {st_ff.sync_b[0], comparator_result_i};
    pin_s = st_ff.sync_a[1];
    src = st_ff.ctl_d[PFG_SRC_SEL] ? st_ff.sync_b[1] : pin_s;
    // ************************************************************
    // noise filter
    // ************************************************************
    // newest four samples, system clock only, adds four cycles
    win = {st_ff.hist, src};
    nxt_st.hist = win[PFG_FILT_LEN-2:0];
    if (&win) begin
      nxt_st.filt = 1'b1;
    end else if (~|win) begin
      nxt_st.filt = 1'b0;
    end
    fin = st_ff.ctl_d[PFG_FILT_EN] ? st_ff.filt : src;
    // ************************************************************
    // edge detector and trip
    // ************************************************************
    nxt_st.prev = fin;
    edge_hit = edge_seen(st_ff.ctl_d[PFG_EDGE], fin, st_ff.prev);
    trip = st_ff.ctl_d[PFG_ARM] && edge_hit;
    // ************************************************************
    // register writes
    // ************************************************************
    if (bus.wr) begin
      case (bus.addr)
        PFG_TC1A_ADDR: begin
          nxt_st.ctl_a = {bus.wdata[7:4], 2'h0, bus.wdata[1:0]};
          nxt_st.foc = bus.wdata[3:2];
        end
        PFG_TC1D_ADDR: nxt_st.ctl_d = bus.wdata;
        PFG_HIGH_ADDR: nxt_st.high = bus.wdata[1:0];
        PFG_FLAG_ADDR: begin
          if (bus.wdata[PFG_FLAG_BIT]) begin
            nxt_st.flag = 1'b0;
          end
        end
        default: begin
          if (is_val(bus.addr)) begin
            nxt_st.vals[vi] = {st_ff.high, bus.wdata};
          end
        end
      endcase
    end
    // ************************************************************
    // register reads
    // ************************************************************
    if (bus.rd) begin
      case (bus.addr)
        PFG_TC1A_ADDR: nxt_st.rdata = st_ff.ctl_a;
        PFG_TC1D_ADDR: nxt_st.rdata = st_ff.ctl_d;
        PFG_HIGH_ADDR: nxt_st.rdata = {6'h00, st_ff.high};
        PFG_FLAG_ADDR: nxt_st.rdata = {7'h00, st_ff.flag};
        default: begin
          if (is_val(bus.addr)) begin
            nxt_st.rdata = st_ff.vals[vi][7:0];
            nxt_st.high = st_ff.vals[vi][9:8];
          end
        end
      endcase
    end
    // ************************************************************
    // fault shutdown
    // ************************************************************
    // set wins over a flag clear or mode write in the same cycle
    if (trip) begin
      nxt_st.ctl_a[7:4] = 4'h0;
      nxt_st.ctl_d[PFG_ARM] = 1'b0;
      nxt_st.flag = 1'b1;
      nxt_st.irq = st_ff.ctl_d[PFG_IRQ_EN];
    end
    // ************************************************************
    // pin mux on the next mode value
    // ************************************************************
    nxt_st.pins[1] = pin_mux(nxt_st.ctl_a[7:6], wave_i[1],
                             port_b_output_i[1]);
    nxt_st.pins[0] = pin_mux(nxt_st.ctl_a[5:4], wave_i[0],
                             port_b_output_i[0]);
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.ctl_a <= PFG_TC1A_RST;
      st_ff.ctl_d <= PFG_TC1D_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign bus.rdata = st_ff.rdata;
  assign bus.irq = st_ff.irq;
  assign pwm_pin_o = st_ff.pins;
  assign force_compare_o = st_ff.foc;
  assign pwm_enable_o = st_ff.ctl_a[1:0];
  assign count_value_o = st_ff.vals[0];
endmodule

// >>> hdl/pfg_host.sv
// host end: cpu side performing ordered 10-bit accesses
`timescale 1ns/1ps
module pfg_host (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  pfg_bus_if.host bus,
  input wire logic wr_req_i,
  input wire logic rd_req_i,
  input wire logic [2:0] sel_i,
  input wire logic [pfg_pkg::PFG_VAL_W-1:0] wval_i,
  input wire logic pin_drive_i,
  output logic [pfg_pkg::PFG_VAL_W-1:0] rval_o,
  output logic done_o,
  output logic busy_o,
  output logic irq_seen_o
);
  import pfg_pkg::*;

  typedef struct packed {
    pfg_host_e state;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] lo;
    logic [PFG_VAL_W-1:0] rval;
    logic [7:0] tgt;
    logic [PFG_VAL_W-1:0] wval;
    logic done;
    logic pin;
    logic irq;
  } pfg_host_s;

  pfg_host_s st_ff;
  pfg_host_s nxt_st;

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.wr = 1'b0;
    nxt_st.rd = 1'b0;
    nxt_st.done = 1'b0;
    nxt_st.pin = pin_drive_i;
    nxt_st.irq = bus.irq;
    case (st_ff.state)
      PFG_H_IDLE: begin
        nxt_st.tgt = 8'(PFG_CNT_ADDR + 8'(sel_i));
        nxt_st.wval = wval_i;
        if (wr_req_i) begin
          nxt_st.state = PFG_H_WHI;
        end else if (rd_req_i) begin
          nxt_st.state = PFG_H_RLO;
        end
      end
      PFG_H_WHI: begin
        nxt_st.addr = PFG_HIGH_ADDR;
        nxt_st.wdata = {6'h00, st_ff.wval[9:8]};
        nxt_st.wr = 1'b1;
        nxt_st.state = PFG_H_WLO;
      end
      PFG_H_WLO: begin
        nxt_st.addr = st_ff.tgt;
        nxt_st.wdata = st_ff.wval[7:0];
        nxt_st.wr = 1'b1;
        nxt_st.state = PFG_H_DONE;
      end
      PFG_H_RLO: begin
        nxt_st.addr = st_ff.tgt;
        nxt_st.rd = 1'b1;
        nxt_st.state = PFG_H_RHI;
      end
      PFG_H_RHI: begin
        nxt_st.addr = PFG_HIGH_ADDR;
        nxt_st.rd = 1'b1;
        nxt_st.state = PFG_H_DONE;
      end
      PFG_H_DONE: begin
        if (st_ff.rd) begin
          nxt_st.lo = bus.rdata;
        end else begin
          // a write leaves the last read value standing
          if (!st_ff.wr) begin
            nxt_st.rval = {bus.rdata[1:0], st_ff.lo};
          end
          nxt_st.done = 1'b1;
          nxt_st.state = PFG_H_IDLE;
        end
      end
      default: nxt_st.state = PFG_H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus.addr = st_ff.addr;
  assign bus.wdata = st_ff.wdata;
  assign bus.wr = st_ff.wr;
  assign bus.rd = st_ff.rd;
  assign bus.event_pin = st_ff.pin;
  assign rval_o = st_ff.rval;
  assign done_o = st_ff.done;
  assign busy_o = (st_ff.state != PFG_H_IDLE);
  assign irq_seen_o = st_ff.irq;
endmodule

// >>> hdl/pfg_pkg.sv
// package: constants and types for the pwm fault guard block
package pfg_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] PFG_TC1A_ADDR = 8'h30;
  localparam logic [7:0] PFG_TC1D_ADDR = 8'h31;
  localparam logic [7:0] PFG_HIGH_ADDR = 8'h32;
  localparam logic [7:0] PFG_CNT_ADDR = 8'h33;
  localparam logic [7:0] PFG_CMPA_ADDR = 8'h34;
  localparam logic [7:0] PFG_CMPB_ADDR = 8'h35;
  localparam logic [7:0] PFG_CMPC_ADDR = 8'h36;
  localparam logic [7:0] PFG_CMPD_ADDR = 8'h37;
  localparam logic [7:0] PFG_FLAG_ADDR = 8'h38;
  localparam logic [7:0] PFG_TC1A_RST = 8'h00;
  localparam logic [7:0] PFG_TC1D_RST = 8'h00;
  // control a fields
  localparam int PFG_COMA_HI = 7;
  localparam int PFG_COMA_LO = 6;
  localparam int PFG_COMB_HI = 5;
  localparam int PFG_COMB_LO = 4;
  localparam int PFG_FOCA = 3;
  localparam int PFG_FOCB = 2;
  localparam int PFG_PWMA = 1;
  localparam int PFG_PWMB = 0;
  // control d fields
  localparam int PFG_ARM = 7;
  localparam int PFG_IRQ_EN = 6;
  localparam int PFG_SRC_SEL = 5;
  localparam int PFG_FILT_EN = 4;
  localparam int PFG_EDGE = 3;
  // flag register field
  localparam int PFG_FLAG_BIT = 0;
  // filter length in samples
  localparam int PFG_FILT_LEN = 4;
  localparam int PFG_VAL_W = 10;
  localparam int PFG_NUM_VAL = 5;
  // ************************************************************
  // host states
  // ************************************************************
  typedef enum logic [2:0] {
    PFG_H_IDLE = 3'b000,
    PFG_H_WHI = 3'b001,
    PFG_H_WLO = 3'b010,
    PFG_H_RLO = 3'b011,
    PFG_H_RHI = 3'b100,
    PFG_H_DONE = 3'b101
  } pfg_host_e;
endpackage

// >>> sim/pfg_properties.sv
// checker: bus order and answer properties of the joined pair
`timescale 1ns/1ps
module pfg_properties (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic irq
);
  import pfg_pkg::*;
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic lo;
  assign lo = addr >= PFG_CNT_ADDR && addr <= PFG_CMPD_ADDR;
  a_no_overlap: assert property (!(wr && rd))
    else $error("write and read together");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_latch_first: assert property (wr && lo |-> $past(wr)
    && $past(addr) == PFG_HIGH_ADDR) else $error("low written first");
  a_wr_pair: assert property (wr && addr == PFG_HIGH_ADDR |=> wr && lo)
    else $error("latch write not followed by low");
  a_low_first: assert property (rd && addr == PFG_HIGH_ADDR
    |-> $past(rd) && $past(lo)) else $error("latch read first");
  a_rd_pair: assert property (rd && lo |=> rd && addr == PFG_HIGH_ADDR)
    else $error("low read not followed by latch");
  a_latch_width: assert property (rd && addr == PFG_HIGH_ADDR
    |=> rdata[7:2] == 6'h00) else $error("latch wider than two bits");
  a_no_trip: assert property (!irq)
    else $error("interrupt while guard unarmed");
  cover property (wr && lo);
  cover property (rd && addr == PFG_HIGH_ADDR);
  cover property ($past(rd) && rdata != 8'h00);
endmodule

// >>> sim/pwm_fault_guard_wide_access_bench.sv
// testbench: host and device pair plus a directly driven device
`timescale 1ns/1ps
module pwm_fault_guard_wide_access_bench;
  import pfg_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr_req = 1'b0, rd_req = 1'b0, cmp = 1'b0, rd_seen = 1'b0;
  logic pdrv = 1'b0, irq_seen;
  logic [9:0] cnt;
  logic [2:0] sel = 3'h0;
  logic [9:0] wval = 10'h000, rval;
  logic [1:0] wave = 2'h0, port_b_output = 2'h0, pin, pin_b, foc_b, pen_b;
  logic done, busy;
  logic [15:0] rnd = 16'h000A;
  int bad_count = 0, n_tests = 0, hits = 0;
  logic [10:0] q_host[$];
  logic [9:0] q_dev[$], vals[5];
  pfg_bus_if bus ();
  pfg_bus_if bus_b ();
  always #10 clk_sys_i = ~clk_sys_i;
  pfg_host i_pfg_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus(bus),
    .wr_req_i(wr_req), .rd_req_i(rd_req), .sel_i(sel), .wval_i(wval),
    .pin_drive_i(pdrv), .rval_o(rval), .done_o(done), .busy_o(busy),
    .irq_seen_o(irq_seen));
  pfg_device i_pfg_device (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .bus(bus), .comparator_result_i(cmp), .wave_i(wave),
    .port_b_output_i(port_b_output), .pwm_pin_o(pin), .force_compare_o(),
    .pwm_enable_o(), .count_value_o(cnt));
  pfg_device i_pfg_device_b (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .bus(bus_b), .comparator_result_i(cmp), .wave_i(wave),
    .port_b_output_i(port_b_output), .pwm_pin_o(pin_b), .force_compare_o(foc_b),
    .pwm_enable_o(pen_b), .count_value_o());
  pfg_properties i_pfg_properties (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .addr(bus.addr), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata),
    .irq(bus.irq));
  // ****
  // helpers
  // ****
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [9:0] e,
    input logic [9:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic hacc(input logic w, input logic [2:0] s,
    input logic [9:0] v);
    @(negedge clk_sys_i);
    sel = s;
    wval = v;
    wr_req = w;
    rd_req = !w;
    pdrv = v[0];
    q_host.push_back({!w, v});
    @(negedge clk_sys_i);
    wr_req = 1'b0;
    rd_req = 1'b0;
    for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk_sys_i);
  endtask
  task automatic bw(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    bus_b.addr = a;
    bus_b.wdata = d;
    bus_b.wr = 1'b1;
    @(negedge clk_sys_i);
    bus_b.wr = 1'b0;
  endtask
  task automatic br(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys_i);
    bus_b.addr = a;
    bus_b.rd = 1'b1;
    q_dev.push_back({2'h0, e});
    @(negedge clk_sys_i);
    bus_b.rd = 1'b0;
  endtask
  task automatic drv(input logic s, input logic v);
    if (s) cmp = v;
    else bus_b.event_pin = v;
  endtask
  task automatic trip(input logic f, input logic s, input logic e);
    int n;
    int h;
    logic [7:0] d;
    d = {2'b11, s, f, e, 3'b000};
    drv(1'b0, !e);
    drv(1'b1, !e);
    repeat (10) @(negedge clk_sys_i);
    bw(PFG_TC1A_ADDR, 8'hF3);
    bw(PFG_TC1D_ADDR, d);
    bw(PFG_FLAG_ADDR, 8'h01);
    br(PFG_FLAG_ADDR, 8'h00);
    drv(!s, e); // unselected input
    repeat (12) @(negedge clk_sys_i);
    if (f) drv(s, e);
    repeat (2) @(negedge clk_sys_i);
    drv(s, !e);
    repeat (12) @(negedge clk_sys_i);
    chk("stray trip", 10'h000, 10'(hits));
    chk("glitch trip", 10'h000, 10'(hits));
    drv(s, e);
    n = 0;
    while (n < 20 && bus_b.irq !== 1'b1) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk("trip delay", f ? 10'h007 : 10'h003, 10'(n));
    @(negedge clk_sys_i);
    chk("pins to port", {8'h00, port_b_output}, {8'h00, pin_b});
    br(PFG_TC1A_ADDR, 8'h03);
    br(PFG_TC1D_ADDR, d & 8'h7F);
    br(PFG_FLAG_ADDR, 8'h01);
    h = hits;
    drv(s, !e);
    repeat (12) @(negedge clk_sys_i);
    drv(s, e);
    repeat (12) @(negedge clk_sys_i);
    chk("unarmed trip", 10'(h), 10'(hits));
    hits = 0;
  endtask
  // ****
  // monitors and sequence
  // ****
  always @(posedge clk_sys_i) rd_seen <= bus_b.rd;
  always @(negedge clk_sys_i) begin
    if (bus_b.irq === 1'b1) hits++;
    if (rd_seen === 1'b1)
      chk("rdata", q_dev.pop_front(), {2'h0, bus_b.rdata});
    if (done === 1'b1 && q_host.size() > 0) begin
      if (q_host[0][10]) chk("wide value", q_host[0][9:0], rval);
      void'(q_host.pop_front());
    end
  end
  initial begin
    #(20 * 20000);
    bad_count++;
    stop_test();
  end
  initial begin
    bus_b.addr = 8'h00;
    bus_b.wdata = 8'h00;
    bus_b.wr = 1'b0;
    bus_b.rd = 1'b0;
    bus_b.event_pin = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    @(negedge clk_sys_i) rst_i = 1'b0;
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      vals[i] = rnd[9:0];
      hacc(1'b1, 3'(i), vals[i]);
    end
    for (int i = 0; i < 5; i++) hacc(1'b0, 3'(i), vals[i]);
    port_b_output = rnd[11:10];
    @(negedge clk_sys_i);
    chk("port pins", {8'h00, port_b_output}, {8'h00, pin});
    chk("host notes", 10'h000, 10'(q_host.size()));
    chk("count value", vals[0], cnt);
    chk("host irq", 10'h000, {9'h000, irq_seen});
    $display("test wide access ended");
    br(PFG_TC1A_ADDR, PFG_TC1A_RST);
    br(PFG_TC1D_ADDR, PFG_TC1D_RST);
    br(8'h3F, 8'h00);
    bw(PFG_TC1A_ADDR, 8'hFF);
    chk("force pulse", 10'h003, {8'h00, foc_b});
    wave = rnd[13:12] ^ 2'h1;
    @(negedge clk_sys_i);
    chk("force end", 10'h000, {8'h00, foc_b});
    chk("pwm enables", 10'h003, {8'h00, pen_b});
    chk("wave pins", {8'h00, wave}, {8'h00, pin_b});
    br(PFG_TC1A_ADDR, 8'hF3);
    $display("test control a ended");
    for (int k = 0; k < 8; k++) trip(k[2], k[1], k[0]);
    $display("test fault guard ended");
    stop_test();
  end
endmodule
